// [design/usbf_front_end.sv]
// pin level logic between the usb core and an analog transceiver
`timescale 1ns/1ns
module usbf_front_end
  import usbf_pkg::*;
#(
  parameter int unsigned SUSP_FS_COUNT = SUSP_FS_BITS,
  parameter int unsigned SUSP_LS_COUNT = SUSP_LS_BITS
)
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                ref_clk_in,
  input  wire logic                speed_select_bit,
  input  wire logic                received_dplus,
  input  wire logic                received_dminus,
  input  wire logic                rx_diff_data,
  input  wire logic                tx_valid,
  input  wire logic [TX_SYM_W-1:0] tx_data,
  output logic                     tx_ready,
  output logic                     rx_valid,
  output logic                     rx_bit,
  output logic                     rx_se0,
  output logic                     transceiver_speed,
  output logic                     suspend_indicator,
  output logic                     transmit_dplus,
  output logic                     transmit_dminus,
  output logic                     transmit_enable_n
);
  usbf_stream_if #(.WIDTH(TX_SYM_W)) fill_if ();
  usbf_stream_if #(.WIDTH(TX_SYM_W)) drain_if ();

  logic                  dplus_q_reg;
  logic                  dminus_q_reg;
  logic                  rxd_q_reg;
  logic                  se0_q_reg;
  logic                  line_q_reg;
  logic                  se0_prev_reg;
  logic                  line_prev_reg;
  logic                  last_level_reg;
  logic                  activity;
  logic                  realign;
  logic                  tx_tick;
  logic                  sample_tick;
  logic                  low_speed;
  logic [SUSP_CNT_W-1:0] idle_cnt_reg;
  logic [SUSP_CNT_W-1:0] idle_limit;
  logic                  suspended_reg;
  usbf_tx_state_e        tx_state_reg;
  logic [1:0]            eop_cnt_reg;
  logic                  nrzi_level_reg;
  logic                  take_sym;
  logic                  sym_eop;
  logic                  sym_bit;
  logic                  dp_next;
  logic                  dm_next;

  // buffer fill side faces the core directly
  assign fill_if.valid = tx_valid;
  assign fill_if.data  = tx_data;
  assign tx_ready      = fill_if.ready; // registered flag inside the buffer

  usbf_buf #(
    .WIDTH (TX_SYM_W),
    .DEPTH (TX_BUF_DEPTH)
  ) u_buf (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .fill    (fill_if),
    .drain   (drain_if)
  );

  usbf_bit_clk u_bit_clk (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .ref_clk_in  (ref_clk_in),
    .resync      (realign),
    .tx_tick     (tx_tick),
    .sample_tick (sample_tick)
  );

  // pin inputs taken once into flops
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dplus_q_reg  <= 1'b1;
      dminus_q_reg <= 1'b0;
      rxd_q_reg    <= 1'b1;
    end
    else
    begin
      dplus_q_reg  <= received_dplus;
      dminus_q_reg <= received_dminus;
      rxd_q_reg    <= rx_diff_data;
    end
  end

  // line state: se0 from the single ended pair, level from the receiver
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      se0_q_reg     <= 1'b0;
      line_q_reg    <= 1'b1;
      se0_prev_reg  <= 1'b0;
      line_prev_reg <= 1'b1;
    end
    else
    begin
      se0_q_reg     <= !dplus_q_reg && !dminus_q_reg;
      line_q_reg    <= rxd_q_reg;
      se0_prev_reg  <= se0_q_reg;
      line_prev_reg <= line_q_reg;
    end
  end

  // any change of line state counts as activity and, while not sending, realigns the bit clock
  assign activity = (se0_q_reg != se0_prev_reg) ||
                    (line_q_reg != line_prev_reg);

  // our own echo must not realign the bit clock, or sent bits would jitter
  assign realign = activity && (tx_state_reg == USBF_TX_IDLE);

  // received bits to the core, nrzi decoded; no stall is possible here,
  // since the wire cannot be paused, so the core must take every bit
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rx_valid       <= 1'b0;
      rx_bit         <= 1'b0;
      rx_se0         <= 1'b0;
      last_level_reg <= 1'b1;
    end
    else
    begin
      rx_valid <= sample_tick && (tx_state_reg == USBF_TX_IDLE);
      if (sample_tick)
      begin
        rx_se0         <= se0_q_reg;
        rx_bit         <= (line_q_reg == last_level_reg);
        last_level_reg <= se0_q_reg ? !low_speed : line_q_reg;
      end
    end
  end

  // speed select pin follows the control bit
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      transceiver_speed <= SPEED_FULL;
    else
      transceiver_speed <= speed_select_bit;
  end

  assign low_speed  = (transceiver_speed != SPEED_FULL);
  assign idle_limit = low_speed ? SUSP_CNT_W'(SUSP_LS_COUNT)
                                : SUSP_CNT_W'(SUSP_FS_COUNT);

  // inactivity counted in bit times; own transmission is activity too
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      idle_cnt_reg <= '0;
    else if (activity || (tx_state_reg != USBF_TX_IDLE))
      idle_cnt_reg <= '0;
    else if (tx_tick && (idle_cnt_reg != idle_limit))
      idle_cnt_reg <= idle_cnt_reg + SUSP_CNT_W'(1);
  end

  // suspend entry at the limit, exit on any bus activity such as resume
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      suspended_reg <= 1'b0;
    else if (activity)
      suspended_reg <= 1'b0;
    else if (idle_cnt_reg >= idle_limit)
      suspended_reg <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      suspend_indicator <= 1'b0;
    else
      suspend_indicator <= suspended_reg;
  end

  // a symbol is taken only on a bit tick while sending may go on;
  // suspend blocks the start of a packet
  assign take_sym = tx_tick && drain_if.valid && !suspended_reg &&
                    ((tx_state_reg == USBF_TX_IDLE) ||
                     (tx_state_reg == USBF_TX_DATA));
  assign drain_if.ready = take_sym;
  assign sym_eop = drain_if.data[TX_EOP_POS];
  assign sym_bit = drain_if.data[TX_BIT_POS];

  // transmit sequencer; an underrun mid packet ends it with an eop
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tx_state_reg <= USBF_TX_IDLE;
      eop_cnt_reg  <= '0;
    end
    else
    begin
      case (tx_state_reg)
        USBF_TX_IDLE:
        begin
          if (take_sym && !sym_eop)
            tx_state_reg <= USBF_TX_DATA;
        end
        USBF_TX_DATA:
        begin
          if (tx_tick && (!take_sym || sym_eop))
          begin
            tx_state_reg <= USBF_TX_SE0;
            eop_cnt_reg  <= EOP_SE0_BITS - 2'h1;
          end
        end
        USBF_TX_SE0:
        begin
          if (tx_tick)
          begin
            if (eop_cnt_reg == '0)
            begin
              tx_state_reg <= USBF_TX_J;
              eop_cnt_reg  <= EOP_J_BITS - 2'h1;
            end
            else
              eop_cnt_reg <= eop_cnt_reg - 2'h1;
          end
        end
        USBF_TX_J:
        begin
          if (tx_tick)
          begin
            if (eop_cnt_reg == '0)
              tx_state_reg <= USBF_TX_IDLE;
            else
              eop_cnt_reg <= eop_cnt_reg - 2'h1;
          end
        end
        default:
          tx_state_reg <= USBF_TX_IDLE;
      endcase
    end
  end

  // nrzi: a zero toggles the line, a one holds it; idle level is j
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      nrzi_level_reg <= 1'b1;
    else if (take_sym && !sym_eop && !sym_bit)
      nrzi_level_reg <= !nrzi_level_reg;
    else if ((tx_state_reg == USBF_TX_SE0) || (tx_state_reg == USBF_TX_IDLE))
      nrzi_level_reg <= 1'b1;
  end

  // j is d+ high at full speed and d- high at low speed
  always_comb
  begin
    dp_next = nrzi_level_reg ^ low_speed;
    dm_next = !(nrzi_level_reg ^ low_speed);
    if (tx_state_reg == USBF_TX_SE0)
    begin
      dp_next = 1'b0;
      dm_next = 1'b0;
    end
  end

  // driven pair and active low enable, all from flops
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      transmit_dplus    <= 1'b1;
      transmit_dminus   <= 1'b0;
      transmit_enable_n <= 1'b1;
    end
    else
    begin
      transmit_dplus    <= dp_next;
      transmit_dminus   <= dm_next;
      transmit_enable_n <= (tx_state_reg == USBF_TX_IDLE);
    end
  end
endmodule : usbf_front_end

// [design/usbf_pkg.sv]
// constants shared by the usb transceiver front end modules
package usbf_pkg;

  // reference edges per bit: 48 MHz -> 12 MHz and 6 MHz -> 1.5 MHz
  localparam int unsigned REF_PER_BIT      = 4;
  localparam int unsigned PHASE_W          = 2;
  localparam logic [1:0]  PHASE_TX         = 2'h3;
  localparam logic [1:0]  PHASE_SAMPLE     = 2'h1;
  localparam logic [1:0]  PHASE_RESYNC     = 2'h3;
  localparam logic [1:0]  PHASE_RESET      = 2'h0;

  // bus inactivity before suspend, in its own unit
  localparam int unsigned SUSP_TIME_US     = 3000;
  localparam int unsigned FS_BIT_RATE_KHZ  = 12000;
  localparam int unsigned LS_BIT_RATE_KHZ  = 1500;
  // least time rounds up to whole bit times
  localparam int unsigned SUSP_FS_BITS =
    (SUSP_TIME_US * FS_BIT_RATE_KHZ + 999) / 1000;
  localparam int unsigned SUSP_LS_BITS =
    (SUSP_TIME_US * LS_BIT_RATE_KHZ + 999) / 1000;
  localparam int unsigned SUSP_CNT_W       = 16;

  // speed select encoding
  localparam logic        SPEED_FULL       = 1'h1;

  // transmit symbol: bit 1 marks end of packet, bit 0 is the data bit
  localparam int unsigned TX_SYM_W         = 2;
  localparam int unsigned TX_EOP_POS       = 1;
  localparam int unsigned TX_BIT_POS       = 0;

  // end of packet: two bit times of se0 then one of idle
  localparam logic [1:0]  EOP_SE0_BITS     = 2'h2;
  localparam logic [1:0]  EOP_J_BITS       = 2'h1;

  // buffer depth in the transmit path
  localparam int unsigned TX_BUF_DEPTH     = 2;

  typedef enum logic [1:0] {
    USBF_TX_IDLE,
    USBF_TX_DATA,
    USBF_TX_SE0,
    USBF_TX_J
  } usbf_tx_state_e;

endpackage : usbf_pkg

// [design/usbf_stream_if.sv]
// valid/ready stream carrier between the front end and its buffer
`timescale 1ns/1ns
interface usbf_stream_if #(
  parameter int unsigned WIDTH = 2
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : usbf_stream_if

// [design/usbf_buf.sv]
// small fifo buffer with registered valid and ready flags
`timescale 1ns/1ns
module usbf_buf
  import usbf_pkg::*;
#(
  parameter int unsigned WIDTH = TX_SYM_W,
  parameter int unsigned DEPTH = TX_BUF_DEPTH
)
(
  input wire logic   sys_clk,
  input wire logic   rst_n,
  usbf_stream_if.snk fill,
  usbf_stream_if.src drain
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             room_reg;
  logic             empty_reg;
  logic             push;
  logic             pop;

  // flags are flops so the ready seen by the source is registered
  assign push        = fill.valid && room_reg;
  assign pop         = drain.ready && !empty_reg;
  assign fill.ready  = room_reg; // straight from a flop, low during reset
  assign drain.valid = !empty_reg;
  assign drain.data  = mem_reg[rd_ptr_reg];

  always_comb
  begin
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + CW'(1);
    else if (pop && !push)
      count_next = count_reg - CW'(1);
  end

  // storage; one entry per slot
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= fill.data;
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0
                                                     : wr_ptr_reg + AW'(1);
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0
                                                     : rd_ptr_reg + AW'(1);
    end
  end

  // occupancy and flags
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      count_reg <= '0;
      room_reg  <= 1'b0;
      empty_reg <= 1'b1;
    end
    else
    begin
      count_reg <= count_next;
      room_reg  <= (count_next != CW'(DEPTH));
      empty_reg <= (count_next == '0);
    end
  end
endmodule : usbf_buf

// [design/usbf_bit_clk.sv]
// bit clock enables derived from the usb reference clock input
`timescale 1ns/1ns
module usbf_bit_clk
  import usbf_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic ref_clk_in,
  input  wire logic resync,
  output logic      tx_tick,
  output logic      sample_tick
);
  logic               ref_q_reg;
  logic               ref_qq_reg;
  logic               ref_edge;
  logic [PHASE_W-1:0] phase_reg;

  // reference is sampled as an ordinary input; 125 MHz sees every edge
  assign ref_edge = ref_q_reg && !ref_qq_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ref_q_reg  <= 1'b0;
      ref_qq_reg <= 1'b0;
    end
    else
    begin
      ref_q_reg  <= ref_clk_in;
      ref_qq_reg <= ref_q_reg;
    end
  end

  // divide by four; a line transition realigns so sampling lands mid bit
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      phase_reg <= PHASE_RESET;
    else if (resync)
      phase_reg <= PHASE_RESYNC;
    else if (ref_edge)
      phase_reg <= phase_reg + PHASE_W'(1);
  end

  // one cycle enables, one each per bit time
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tx_tick     <= 1'b0;
      sample_tick <= 1'b0;
    end
    else
    begin
      tx_tick     <= ref_edge && !resync && (phase_reg == PHASE_TX);
      sample_tick <= ref_edge && !resync && (phase_reg == PHASE_SAMPLE);
    end
  end
endmodule : usbf_bit_clk

// [testbench/usbf_xcvr_model.sv]
// behavioural analog transceiver and usb reference clock source
`timescale 1ns/1ns
module usbf_xcvr_model
#(
  parameter int FS_HALF = 10,
  parameter int LS_HALF = 84
)
(
  input  wire logic       full_speed,
  input  wire logic       host_drive,
  input  wire logic [1:0] host_line,
  input  wire logic       transmit_dplus,
  input  wire logic       transmit_dminus,
  input  wire logic       transmit_enable_n,
  output logic            ref_clk_in,
  output logic            received_dplus,
  output logic            received_dminus,
  output logic            rx_diff_data
);
  logic [1:0] bus;

  // odd start phase keeps reference edges off the system clock edges
  initial
  begin
    ref_clk_in = 1'b0;
    #3;
    forever #(full_speed ? FS_HALF : LS_HALF) ref_clk_in = ~ref_clk_in;
  end

  // drivers win while enabled, then the host, else the pull-up gives idle
  always_comb
    if (!transmit_enable_n)
      bus = {transmit_dplus, transmit_dminus};
    else if (host_drive)
      bus = host_line;
    else
      bus = full_speed ? 2'h2 : 2'h1;

  assign received_dplus  = bus[1];
  assign received_dminus = bus[0];
  assign rx_diff_data    = bus[1];
endmodule : usbf_xcvr_model

// [testbench/usbf_front_end_asserts.sv]
// concurrent checks on the front end ports
`timescale 1ns/1ns
module usbf_fe_asserts
  import usbf_pkg::*;
#(
  parameter int unsigned SUSP_FS_COUNT = SUSP_FS_BITS,
  parameter int unsigned SUSP_LS_COUNT = SUSP_LS_BITS
)
(
  input wire logic                sys_clk,
  input wire logic                rst_n,
  input wire logic                ref_clk_in,
  input wire logic                speed_select_bit,
  input wire logic                received_dplus,
  input wire logic                received_dminus,
  input wire logic                rx_diff_data,
  input wire logic                tx_valid,
  input wire logic [TX_SYM_W-1:0] tx_data,
  input wire logic                tx_ready,
  input wire logic                rx_valid,
  input wire logic                rx_bit,
  input wire logic                rx_se0,
  input wire logic                transceiver_speed,
  input wire logic                suspend_indicator,
  input wire logic                transmit_dplus,
  input wire logic                transmit_dminus,
  input wire logic                transmit_enable_n
);
  // conservative cycle floors: reference edges are never faster than this
  localparam int FS_MIN = SUSP_FS_COUNT * 8;
  localparam int LS_MIN = SUSP_LS_COUNT * 64;
  logic [19:0] quiet;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // system cycles since the bus last moved
  always_ff @(posedge sys_clk)
    if (!rst_n || $changed(rx_diff_data) ||
        $changed(received_dplus | received_dminus))
      quiet <= 20'h0;
    else if (~&quiet)
      quiet <= quiet + 20'h1;

  sequence se0_in;
    (!received_dplus && !received_dminus) [*8];
  endsequence
  sequence se0_out;
    !transmit_enable_n && !transmit_dplus && !transmit_dminus;
  endsequence

  chk_bit_spacing: assert property (rx_valid |=> !rx_valid [*8])
    else $error("receive samples closer than a bit time");
  chk_speed_copy: assert property ($changed(speed_select_bit) |=>
    transceiver_speed == $past(speed_select_bit))
    else $error("speed output does not follow speed bit");
  chk_se0_seen: assert property (se0_in ##0 rx_valid |-> rx_se0)
    else $error("se0 on both lines not reported");
  chk_se0_false: assert property (
    (received_dplus ^ received_dminus) [*8] ##0 rx_valid |-> !rx_se0)
    else $error("se0 reported on a driven line");
  chk_still_one: assert property (rx_valid && (received_dplus ||
    received_dminus) && quiet >= (transceiver_speed ? 24 : 100) |-> rx_bit)
    else $error("unchanged line not decoded as one");
  chk_susp_late: assert property ($rose(suspend_indicator) |->
    quiet >= (transceiver_speed ? FS_MIN : LS_MIN))
    else $error("suspend entered too early");
  chk_wake_exit: assert property (suspend_indicator &&
    $changed(rx_diff_data) |-> ##[1:12] !suspend_indicator)
    else $error("suspend kept after bus activity");
  chk_pair_split: assert property (!transmit_enable_n |->
    !(transmit_dplus && transmit_dminus))
    else $error("both transmit lines high");
  chk_eop_to_j: assert property (se0_out ##1 (transmit_dplus ||
    transmit_dminus) |-> transmit_dplus == transceiver_speed)
    else $error("end of packet not followed by idle");
  chk_release_j: assert property ($rose(transmit_enable_n) |->
    $past(transmit_dplus) == transceiver_speed && $past(transmit_dminus)
    != transceiver_speed)
    else $error("drivers released before idle state");
  // receive sampling goes on while suspended; only the drivers must stay off
  chk_susp_quiet: assert property (suspend_indicator |->
    transmit_enable_n)
    else $error("activity while suspended");
  chk_tx_no_rx: assert property (!transmit_enable_n |-> !rx_valid)
    else $error("receive sample while transmitting");
endmodule : usbf_fe_asserts

bind usbf_front_end usbf_fe_asserts #(
  .SUSP_FS_COUNT(SUSP_FS_COUNT), .SUSP_LS_COUNT(SUSP_LS_COUNT)
) i_usbf_fe_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
  .ref_clk_in(ref_clk_in), .speed_select_bit(speed_select_bit),
  .received_dplus(received_dplus), .received_dminus(received_dminus),
  .rx_diff_data(rx_diff_data), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_bit(rx_bit),
  .rx_se0(rx_se0), .transceiver_speed(transceiver_speed),
  .suspend_indicator(suspend_indicator), .transmit_dplus(transmit_dplus),
  .transmit_dminus(transmit_dminus), .transmit_enable_n(transmit_enable_n));

// [testbench/tb_top.sv]
// self-checking bench for the usb transceiver front end
`timescale 1ns/1ns
module tb_top;
  import usbf_pkg::*;
  localparam int FS_N = 200;
  localparam int LS_N = 50;
  logic                sys_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                full = 1'b1;
  logic                host_drive = 1'b0;
  logic [1:0]          host_line = 2'h2;
  logic                tx_valid = 1'b0;
  logic [TX_SYM_W-1:0] tx_data = 2'h0;
  logic                ref_clk, r_dp, r_dm, r_diff, tx_ready, rx_valid;
  logic                rx_bit, rx_se0, t_speed, susp, t_dp, t_dm, t_en_n;
  logic [1:0]          line;
  logic [1:0]          prev;
  logic [1:0]          rx_q[$];
  logic [1:0]          tx_q[$];
  logic                rx_arm = 1'b0;
  logic                rx_go = 1'b0;
  logic                stalled;
  int                  fail_count = 0;
  int                  checks = 0;
  int                  seed = 32'hed1b;
  int                  k;

  always #4 sys_clk = ~sys_clk;

  usbf_front_end #(.SUSP_FS_COUNT(FS_N), .SUSP_LS_COUNT(LS_N))
  i_usbf_front_end (.sys_clk(sys_clk), .rst_n(rst_n), .ref_clk_in(ref_clk),
    .speed_select_bit(full), .received_dplus(r_dp), .received_dminus(r_dm),
    .rx_diff_data(r_diff), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_bit(rx_bit),
    .rx_se0(rx_se0), .transceiver_speed(t_speed), .suspend_indicator(susp),
    .transmit_dplus(t_dp), .transmit_dminus(t_dm),
    .transmit_enable_n(t_en_n));

  usbf_xcvr_model i_usbf_xcvr_model (.full_speed(full),
    .host_drive(host_drive), .host_line(host_line), .transmit_dplus(t_dp),
    .transmit_dminus(t_dm), .transmit_enable_n(t_en_n), .ref_clk_in(ref_clk),
    .received_dplus(r_dp), .received_dminus(r_dm), .rx_diff_data(r_diff));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // a wait that ran out is a mismatch and ends the run
  task automatic bound(input int n, input int lim);
    check(n < lim, 1'b1);
    if (n >= lim)
      wrap_up();
  endtask : bound

  task automatic bit_time(input logic [1:0] lv);
    host_line = lv;
    repeat (4) @(posedge ref_clk);
    #2;
  endtask : bit_time

  // host frame: leading zero, random bits, two se0 bits, idle
  task automatic host_frame(input int n);
    logic [15:0] bits;
    logic [1:0]  lv;
    bits = $random(seed);
    for (int i = 0; i < n; i++)
      rx_q.push_back({1'b0, bits[i]});
    rx_q.push_back(2'h2);
    lv = full ? 2'h2 : 2'h1;
    @(posedge ref_clk);
    #2;
    host_line = lv;
    host_drive = 1'b1;
    rx_go = 1'b0;
    rx_arm = 1'b1;
    lv = ~lv;
    bit_time(lv);
    for (int i = 0; i < n; i++)
    begin
      if (!bits[i])
        lv = ~lv;
      bit_time(lv);
    end
    bit_time(2'h0);
    bit_time(2'h0);
    bit_time(full ? 2'h2 : 2'h1);
    host_drive = 1'b0;
  endtask : host_frame

  // core packet, offered back to back so the buffer fills and refuses
  task automatic send_pkt(input int n);
    logic [15:0] bits;
    bits = $random(seed);
    stalled = 1'b0;
    @(posedge sys_clk);
    #1;
    for (int i = 0; i <= n; i++)
    begin
      tx_data = (i == n) ? 2'h2 : {1'b0, bits[i]};
      tx_q.push_back(tx_data);
      if (i == n)
        tx_q.push_back(2'h2);
      tx_valid = 1'b1;
      k = 0;
      do
      begin
        @(posedge sys_clk);
        k++;
        stalled = stalled | (tx_ready !== 1'b1);
      end
      while (tx_ready !== 1'b1 && k < 5000);
      bound(k, 5000);
      #1;
    end
    tx_valid = 1'b0;
  endtask : send_pkt

  task automatic settle;
    k = 0;
    while ((rx_arm || tx_q.size() != 0 || t_en_n !== 1'b1) && k < 20000)
    begin
      @(posedge sys_clk);
      k++;
    end
    bound(k, 20000);
  endtask : settle

  // receive side: compare from the bit after the first decoded zero of the frame on
  always @(posedge sys_clk)
    if (rx_arm && rx_valid === 1'b1)
    begin
      if (rx_go)
      begin
        check({rx_se0, rx_bit & ~rx_se0}, rx_q.pop_front());
        rx_arm = (rx_q.size() != 0);
      end
      rx_go = rx_go || (rx_bit === 1'b0);
    end

  // transmit side: decode the driven pair at mid bit
  initial
    forever
    begin
      @(negedge t_en_n);
      prev = t_speed ? 2'h2 : 2'h1;
      while (t_en_n === 1'b0)
      begin
        repeat (2) @(posedge ref_clk);
        line = {t_dp, t_dm};
        if (t_en_n === 1'b0 && tx_q.size() != 0)
          check(line == 2'h0 ? 2'h2 : {1'b0, line == prev},
                tx_q.pop_front());
        if (line != 2'h0)
          prev = line;
        repeat (2) @(posedge ref_clk);
      end
    end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    #1;
    check({tx_ready, rx_valid, susp, t_speed, t_dp, t_dm, t_en_n},
          7'h0d);
    rst_n = 1'b1;
    for (int s = 1; s >= 0; s--)
    begin
      full = s[0];
      repeat (40) @(posedge ref_clk);
      #2;
      check(t_speed, full);
      host_frame(12);
      settle();
      send_pkt(10);
      check(stalled, 1'b1);
      settle();
    end
    // low speed now: leave the bus idle after one activity burst
    @(posedge ref_clk);
    #2;
    host_drive = 1'b1;
    bit_time(2'h2);
    host_drive = 1'b0;
    k = 0;
    while (susp !== 1'b1 && k < 4 * LS_N + 100)
    begin
      @(posedge ref_clk);
      k++;
    end
    check(k >= 4 * LS_N - 4 && k <= 4 * LS_N + 8, 1'b1);
    #2;
    host_drive = 1'b1;
    k = 0;
    while (susp !== 1'b0 && k < 20)
    begin
      @(posedge sys_clk);
      k++;
    end
    bound(k, 20);
    host_drive = 1'b0;
    check(rx_q.size() + tx_q.size(), 16'h0);
    wrap_up();
  end
endmodule : tb_top
